// File: rtl/clkgen_ctrl.sv
// oscillator pin mode and cpu clock divider control with ahb-lite slave
//
// Notes on behaviour
// - reset clears pin mode register: both pins input port, gain bit zero.
// - mode pair 00/10 input, 01 crystal, 11 external clock on second pin.
// - gain bit accepts one change per reset, later writes ignored.
// - gain set with crystal clock on cpu: cpu clock gated 5.00-19.35 us.
// - gain set with external clock on cpu: gated for 160 external clocks.
// - gain 1, stop release: gate timed or 160 external clocks.
// - gain 1, crystal on cpu, stop release: stabilization count first.
// - reset loads divider register with one, divide by two.
// - divider values 0-4 divide by 1,2,4,8,16; others prohibited.
// - divider touches only the cpu clock; peripheral clock stays undivided.
// - fastest instruction takes two cpu clock periods.
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "clkgen_defs.svh"
module clkgen_ctrl (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // clock system status
  input wire logic cpu_on_high_speed,
  input wire logic ext_clk_edge,
  input wire logic stop_release,
  input wire logic stab_done,
  // clock control outputs
  output clkgen_pkg::pin_mode_e pin_mode,
  output logic high_freq_gain_ctrl,
  output logic stab_start,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic instr_slot_en
);
  import clkgen_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // bus address phase capture
  logic wr_pend_r;
  logic rd_pend_r;
  logic [15:0] addr_r;
  logic [7:0] pin_reg_r;
  logic [7:0] div_reg_r;
  logic gain_locked_r;
  gate_state_e gate_r;
  logic ph_valid;
  logic wr_pin;
  logic wr_div;
  logic gain_rise;

  function automatic logic [7:0] reg_read(input logic [15:0] a, input logic [7:0] p,
                                          input logic [7:0] d);
    if (a == `OFS_PIN_MODE)
      reg_read = p;
    else if (a == `OFS_CPU_DIV)
      reg_read = d;
    else
      reg_read = 8'h00;
  endfunction

  assign ph_valid = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 16'h0000;
    end else begin
      wr_pend_r <= ph_valid && hwrite;
      rd_pend_r <= ph_valid && !hwrite;
      if (ph_valid) begin
        addr_r <= haddr[15:0];
      end
    end
  end

  // read data registered in the address phase so hrdata comes from flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ph_valid && !hwrite) begin
      hrdata <= {24'h000000, reg_read(haddr[15:0], pin_reg_r, div_reg_r)};
    end
  end

  assign wr_pin = wr_pend_r && addr_r == `OFS_PIN_MODE;
  assign wr_div = wr_pend_r && addr_r == `OFS_CPU_DIV;

  ////////////////////////////////////////////////////////////////////////
  // oscillator pin mode register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_reg_r <= `RST_PIN_MODE;
    end else if (wr_pin) begin
      pin_reg_r[`BIT_EXT_SEL] <= hwdata[`BIT_EXT_SEL];
      pin_reg_r[`BIT_XTAL_SEL] <= hwdata[`BIT_XTAL_SEL];
      // bits 1..5 are kept zero whatever software writes
      if (!gain_locked_r) begin
        pin_reg_r[`BIT_GAIN] <= hwdata[`BIT_GAIN];
      end
    end
  end

  // lock on the first write that changes the gain bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gain_locked_r <= 1'b0;
    end else if (wr_pin && hwdata[`BIT_GAIN] != pin_reg_r[`BIT_GAIN]) begin
      gain_locked_r <= 1'b1;
    end
  end
  assign gain_rise = wr_pin && !gain_locked_r && hwdata[`BIT_GAIN] && !pin_reg_r[`BIT_GAIN];

  always_comb begin
    unique case ({pin_reg_r[`BIT_EXT_SEL], pin_reg_r[`BIT_XTAL_SEL]})
      2'b01: pin_mode = pin_crystal;
      2'b11: pin_mode = pin_ext;
      default: pin_mode = pin_input;
    endcase
  end
  assign high_freq_gain_ctrl = pin_reg_r[`BIT_GAIN];

  ////////////////////////////////////////////////////////////////////////
  // cpu clock divider register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg_r <= `RST_CPU_DIV;
    end else if (wr_div) begin
      div_reg_r <= {5'h00, hwdata[2:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cpu clock gating after gain set or stop release
  logic tmr_load;
  logic [7:0] tmr_count;
  logic tmr_done;
  logic ext_mode;

  assign ext_mode = (pin_mode == pin_ext);

  always_comb begin
    tmr_load = 1'b0;
    tmr_count = 8'(`GATE_CYCLES);
    if (gate_r == g_run && cpu_on_high_speed && gain_rise) begin
      tmr_load = 1'b1;
      tmr_count = ext_mode ? 8'(`EXT_GATE_EDGES) : 8'(`GATE_CYCLES);
    end else if (gate_r == g_run && stop_release && high_freq_gain_ctrl) begin
      tmr_load = !(cpu_on_high_speed && pin_mode == pin_crystal);
      tmr_count = (cpu_on_high_speed && ext_mode) ? 8'(`EXT_GATE_EDGES)
                                                  : 8'(`GATE_CYCLES);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_r <= g_run;
    end else begin
      unique case (gate_r)
        g_run: begin
          if (tmr_load) begin
            gate_r <= (cpu_on_high_speed && ext_mode) ? g_ext : g_time;
          end else if (stop_release && high_freq_gain_ctrl) begin
            gate_r <= g_stab;
          end
        end
        g_time: if (tmr_done) gate_r <= g_run;
        g_ext: if (tmr_done) gate_r <= g_run;
        g_stab: if (stab_done) gate_r <= g_run;
      endcase
    end
  end

  assign stab_start = (gate_r == g_run) && stop_release && high_freq_gain_ctrl &&
                      cpu_on_high_speed && pin_mode == pin_crystal;

  gate_timer #(.W(8)) u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(tmr_load),
    .count(tmr_count),
    .step(gate_r == g_ext ? ext_clk_edge : 1'b1),
    .done(tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // cpu clock enable; prohibited ratios fall back to the largest division
  logic [2:0] ratio;
  logic cpu_en;
  logic slot_r;
  assign ratio = (div_reg_r[2:0] > `DIV_MAX) ? `DIV_MAX : div_reg_r[2:0];

  cpu_clk_div #(.W(4)) u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .ratio(ratio),
    .gate(gate_r != g_run),
    .cpu_en(cpu_en)
  );
  assign cpu_clk_en = cpu_en;
  assign periph_clk_en = 1'b1;

  // instruction slot every second cpu clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slot_r <= 1'b0;
    end else if (cpu_en) begin
      slot_r <= !slot_r;
    end
  end
  assign instr_slot_en = cpu_en && slot_r;
endmodule

// File: shared/clkgen_defs.svh
// offsets, field positions, reset values and timing counts of the clock control block
`ifndef CLKGEN_DEFS_SVH
`define CLKGEN_DEFS_SVH
`define OFS_PIN_MODE 16'hff9f
`define OFS_CPU_DIV 16'hfffb
`define RST_PIN_MODE 8'h00
`define RST_CPU_DIV 8'h01
`define BIT_EXT_SEL 7
`define BIT_XTAL_SEL 6
`define BIT_GAIN 0
`define DIV_MAX 3'h4
// gate times: printed figures in ns, clock period in ns
`define CLK_PERIOD_NS 100
`define GATE_MIN_NS 5000
`define GATE_MAX_NS 19350
// least time rounded up to whole cycles
`define GATE_CYCLES ((`GATE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EXT_GATE_EDGES 160
`endif

// File: shared/clkgen_pkg.sv
// types of the clock control block
package clkgen_pkg;
  typedef enum logic [1:0] {
    pin_input = 2'b00,
    pin_crystal = 2'b01,
    pin_ext = 2'b11
  } pin_mode_e;
  typedef enum logic [1:0] {
    g_run = 2'b00,
    g_time = 2'b01,
    g_ext = 2'b10,
    g_stab = 2'b11
  } gate_state_e;
endpackage

// File: rtl/cpu_clk_div.sv
// power-of-two cpu clock enable divider
`timescale 1ns/1ps
module cpu_clk_div #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic [2:0] ratio,
  input wire logic gate,
  // output
  output logic cpu_en
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] mask;
  always_comb begin
    mask = W'((5'h1 << ratio) - 5'h1);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= '0;
    end else if (gate) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= (cnt_r & mask) == mask ? '0 : cnt_r + 1'b1;
    end
  end
  assign cpu_en = !gate && ((cnt_r & mask) == mask);
endmodule

// File: rtl/gate_timer.sv
// down counter used to hold off the cpu clock
`timescale 1ns/1ps
module gate_timer #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic load,
  input wire logic [W-1:0] count,
  input wire logic step,
  // status
  output logic done
);
  logic [W-1:0] cnt_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= count;
    end else if (step && cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end
  assign done = (cnt_r == '0);
endmodule

// File: verif/clkgen_ctrl_asserts.sv
// concurrent checks on the clock control block ports
`timescale 1ns/1ps
module clkgen_ctrl_asserts
  import clkgen_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // status and control
  input wire logic cpu_on_high_speed,
  input wire logic stop_release,
  input wire clkgen_pkg::pin_mode_e pin_mode,
  input wire logic high_freq_gain_ctrl,
  input wire logic stab_start,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic instr_slot_en
);
  logic [7:0] idle_r;
  logic chg_r;
  wire xtal = pin_mode == pin_crystal && cpu_on_high_speed;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////
  // saturating length of the current cpu clock gap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) idle_r <= 8'h00;
    else if (cpu_clk_en) idle_r <= 8'h00;
    else if (idle_r != 8'hff) idle_r <= idle_r + 8'h01;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) chg_r <= 1'b0;
    else if ($changed(high_freq_gain_ctrl)) chg_r <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////
  a_periph_undivided: assert property (periph_clk_en)
    else $error("peripheral clock gated");
  a_slot_on_cpu: assert property (instr_slot_en |-> cpu_clk_en)
    else $error("slot without cpu clock");
  a_mode_legal: assert property (pin_mode != 2'b10)
    else $error("illegal pin mode code");
  a_gain_once: assert property (chg_r |-> $stable(high_freq_gain_ctrl))
    else $error("gain bit changed twice");
  a_gate_xtal: assert property ($rose(high_freq_gain_ctrl) && xtal
    |-> ##45 idle_r > 8'd44 ##[1:149] cpu_clk_en) else $error("crystal gate length");
  a_gate_ext: assert property ($rose(high_freq_gain_ctrl)
    && pin_mode == pin_ext && cpu_on_high_speed |-> ##100 idle_r > 8'd98)
    else $error("external gate too short");
  a_stop_stab: assert property (stop_release && high_freq_gain_ctrl && xtal
    |-> ##[0:1] stab_start) else $error("no stabilization start");
  a_stop_timed: assert property (stop_release && high_freq_gain_ctrl
    && !cpu_on_high_speed |-> ##45 idle_r > 8'd44) else $error("stop gate too short");
  c_gain_set: cover property ($rose(high_freq_gain_ctrl));
  c_stab: cover property (stab_start);
  c_slot: cover property (instr_slot_en);
endmodule
bind clkgen_ctrl clkgen_ctrl_asserts clkgen_ctrl_asserts_inst (.*);

// File: verif/clkgen_ctrl_tb.sv
// self-checking bench for the clock control block
`timescale 1ns/1ps
`include "clkgen_defs.svh"
module clkgen_ctrl_tb;
  import clkgen_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, cpu_on_high_speed = 0;
  logic ext_clk_edge = 0, stop_release = 0, stab_done = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rdat;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2, v;
  logic hreadyout, hresp, stab_start, cpu_clk_en, periph_clk_en;
  logic instr_slot_en, high_freq_gain_ctrl;
  pin_mode_e pin_mode;
  int num_errors = 0, n_tests = 0, n, c0, c1, c2;
  clkgen_ctrl clkgen_ctrl_inst (.*, .hready(hreadyout));
  always #50 hclk = ~hclk;
  always @(posedge hclk) ext_clk_edge <= ~ext_clk_edge;
  ////////////////////////////////////////////////////////////////
  function automatic logic [1:0] exp_mode(logic [1:0] m);
    return (m == 2'b10) ? 2'b00 : m;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // gap until the cpu clock comes back, counted on settled falling edges
  // first look is a settled edge, so the launching edge cannot race the check
  task automatic gate(input int lo, input int hi);
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (cpu_clk_en !== 1'b1 && n < 2000);
    n_tests++;
    if (n < lo || n > hi) begin
      num_errors++;
      $display("MISMATCH %0t gate %0d cycles", $time, n);
    end
    @(posedge hclk);
  endtask
  task automatic count(input int cyc);
    c0 = 0;
    c1 = 0;
    c2 = 0;
    repeat (cyc) begin
      @(negedge hclk);
      c0 += (cpu_clk_en === 1'b1);
      c1 += (instr_slot_en === 1'b1);
      c2 += (periph_clk_en === 1'b1);
    end
    @(posedge hclk);
  endtask
  task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {16'h0000, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdat = hrdata;
  endtask
  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask
  task automatic pulse_stop;
    stop_release <= 1'b1;
    @(posedge hclk);
    stop_release <= 1'b0;
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    num_errors++;
    give_verdict;
  end
  initial begin
    void'($urandom(21532));
    do_reset;
    bus(`OFS_PIN_MODE, 1'b0, 8'h00);
    chk(rdat, `RST_PIN_MODE);
    chk(pin_mode, pin_input);
    chk({hreadyout, hresp}, 2'b10);
    bus(`OFS_CPU_DIV, 1'b0, 8'h00);
    chk(rdat, `RST_CPU_DIV);
    count(64);
    chk(c0, 32);
    for (int i = 0; i < 8; i++) begin
      v = (i < 5) ? 3'(i) : 3'($urandom % 5);
      bus(`OFS_CPU_DIV, 1'b1, {5'h00, v});
      bus(`OFS_CPU_DIV, 1'b0, 8'h00);
      chk(rdat, v);
      count(64);
      chk(c0, 64 >> v);
      chk(c1, 32 >> v);
      chk(c2, 64);
    end
    // prohibited ratio: reads back as written, divides as the largest ratio
    bus(`OFS_CPU_DIV, 1'b1, 8'h07);
    bus(`OFS_CPU_DIV, 1'b0, 8'h00);
    chk(rdat, 8'h07);
    count(64);
    chk(c0, 4);
    v = 3'h4;
    // unmapped place reads zero
    bus(16'h0100 + 16'($urandom % 256), 1'b1, 8'hff);
    bus(16'h0100 + 16'($urandom % 256), 1'b0, 8'h00);
    chk(rdat, 0);
    for (int m = 0; m < 4; m++) begin
      bus(`OFS_PIN_MODE, 1'b1, {2'(m), 6'h00});
      bus(`OFS_PIN_MODE, 1'b0, 8'h00);
      chk(rdat, {2'(m), 6'h00});
      chk(pin_mode, exp_mode(2'(m)));
    end
    cpu_on_high_speed <= 1'b1;
    bus(`OFS_PIN_MODE, 1'b1, 8'h40);
    bus(`OFS_PIN_MODE, 1'b1, 8'h41);
    gate(48, 195);
    chk(high_freq_gain_ctrl, 1'b1);
    bus(`OFS_PIN_MODE, 1'b1, 8'h40);
    bus(`OFS_PIN_MODE, 1'b0, 8'h00);
    chk(rdat, 8'h41);
    pulse_stop;
    count(20);
    chk(c0, 0);
    stab_done <= 1'b1;
    gate(1 << v, 2 + (1 << v));
    stab_done <= 1'b0;
    // second reset in mid-run unlocks the gain bit again
    do_reset;
    bus(`OFS_PIN_MODE, 1'b0, 8'h00);
    chk(rdat, `RST_PIN_MODE);
    bus(`OFS_PIN_MODE, 1'b1, 8'hc0);
    bus(`OFS_PIN_MODE, 1'b1, 8'hc1);
    gate(300, 340);
    cpu_on_high_speed <= 1'b0;
    pulse_stop;
    gate(44, 195);
    give_verdict;
  end
endmodule
